// [verilog/fwsr_top.sv]
// flash write status controller: polls a flash after program or erase
// assumes apb master software and a byte-wide flash on the pins
//
// Design decisions made here: the placing of the registers and the APB register port.
module fwsr_top
  import fwsr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  dq_in,
  output logic [7:0]       dq_out,
  output logic             dq_oe_n,
  output logic [16:0]      flash_addr,
  output logic             chip_select_n,
  output logic             output_strobe_n,
  output logic             write_strobe_n
);
  fwsr_bus_if bus ();
  fwsr_cycle u_cycle (
    .pclk            (pclk),
    .presetn         (presetn),
    .bus             (bus),
    .dq_in           (dq_in),
    .dq_out          (dq_out),
    .dq_oe_n         (dq_oe_n),
    .flash_addr      (flash_addr),
    .chip_select_n   (chip_select_n),
    .output_strobe_n (output_strobe_n),
    .write_strobe_n  (write_strobe_n)
  );
  typedef struct packed {
    fwsr_state_t st;
    fwsr_mode_t  mode;
    logic [16:0] addr_reg;
    logic [7:0]  data_reg;
    logic [7:0]  last_reg;
    logic [7:0]  prev_reg;
    logic        have_prev;
    logic        tout_seen;
    logic        busy;
    logic        done;
    logic        fail;
    logic        susp;
    logic        req;
    logic        wr;
    logic [16:0] baddr;
    logic [7:0]  bwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fwsr_top_t;
  fwsr_top_t s_reg, s_next;
  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b, input fwsr_mode_t m);
    toggled = (a[FWSR_TOG1_BIT] != b[FWSR_TOG1_BIT]) ||
              (m == FWSR_MODE_ERASE && a[FWSR_TOG2_BIT] != b[FWSR_TOG2_BIT]);
  endfunction
  always_comb begin
    s_next = s_reg;
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    // apb: answer one cycle after the setup cycle
    if (psel && !penable) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      if (paddr == FWSR_OFF_CTRL) begin
        s_next.prdata = {28'h000_0000, 1'b0, s_reg.mode, 1'b0};
      end else if (paddr == FWSR_OFF_ADDR) begin
        s_next.prdata = {15'h0000, s_reg.addr_reg};
      end else if (paddr == FWSR_OFF_DATA) begin
        s_next.prdata = {24'h00_0000, s_reg.data_reg};
      end else if (paddr == FWSR_OFF_STATUS) begin
        s_next.prdata = {28'h000_0000, s_reg.susp, s_reg.fail, s_reg.done, s_reg.busy};
      end else if (paddr == FWSR_OFF_LAST) begin
        s_next.prdata = {24'h00_0000, s_reg.last_reg};
      end else begin
        s_next.pslverr = 1'b1;
      end
    end
    if (psel && penable && pwrite && s_reg.pready && !s_reg.pslverr) begin
      if (paddr == FWSR_OFF_ADDR) begin
        s_next.addr_reg = pwdata[16:0];
      end else if (paddr == FWSR_OFF_DATA) begin
        s_next.data_reg = pwdata[7:0];
      end else if (paddr == FWSR_OFF_CTRL && s_reg.st == FWSR_IDLE) begin
        s_next.mode = fwsr_mode_t'(pwdata[FWSR_CTRL_MODE_LSB +: 2]);
        if (pwdata[FWSR_CTRL_RESET_BIT]) begin
          s_next.st = FWSR_RESETW;
          s_next.busy = 1'b1;
          s_next.req = 1'b1;
          s_next.wr = 1'b1;
          s_next.baddr = s_reg.addr_reg;
          s_next.bwdata = FWSR_CMD_RESET;
        end else if (pwdata[FWSR_CTRL_GO_BIT]) begin
          // each start begins from the first double read
          s_next.st = FWSR_READ;
          s_next.busy = 1'b1;
          s_next.done = 1'b0;
          s_next.fail = 1'b0;
          s_next.susp = 1'b0;
          s_next.have_prev = 1'b0;
          s_next.tout_seen = 1'b0;
          s_next.req = 1'b1;
          s_next.wr = 1'b0;
          s_next.baddr = s_reg.addr_reg;
        end
      end
    end
    case (s_reg.st)
      FWSR_IDLE: begin
      end
      FWSR_READ: begin
        if (bus.done) begin
          s_next.req = 1'b0;
          // keep the earlier byte so two reads in a row can be compared
          s_next.prev_reg = s_reg.last_reg;
          s_next.last_reg = bus.rdata;
          s_next.st = FWSR_EVAL;
        end
      end
      FWSR_EVAL: begin
        s_next.st = FWSR_READ;
        s_next.req = 1'b1;
        // in the toggle and erase modes the first read of a start only primes the pair; poll mode judges it alone
        s_next.have_prev = 1'b1;
        if (s_reg.mode == FWSR_MODE_POLL) begin
          if (s_reg.last_reg[FWSR_POLL_BIT] == s_reg.data_reg[FWSR_POLL_BIT]) begin
            s_next.st = FWSR_FINAL;
          end else if (s_reg.tout_seen) begin
            s_next.st = FWSR_IDLE;
            s_next.req = 1'b0;
            s_next.busy = 1'b0;
            s_next.fail = 1'b1;
          end else if (s_reg.last_reg[FWSR_TOUT_BIT]) begin
            s_next.tout_seen = 1'b1;
          end
        end else if (s_reg.have_prev && s_reg.prev_reg != s_reg.last_reg) begin
          if (!toggled(s_reg.prev_reg, s_reg.last_reg, s_reg.mode)) begin
            s_next.st = FWSR_FINAL;
          end else if (s_reg.tout_seen) begin
            s_next.st = FWSR_IDLE;
            s_next.req = 1'b0;
            s_next.busy = 1'b0;
            s_next.fail = 1'b1;
          end else if (s_reg.last_reg[FWSR_TOUT_BIT]) begin
            s_next.tout_seen = 1'b1;
          end
        end else if (s_reg.have_prev) begin
          s_next.st = FWSR_FINAL;
        end
        // only toggle_two moved: a change from status to array data is no suspend
        if (s_reg.mode == FWSR_MODE_ERASE && s_reg.have_prev &&
            (s_reg.prev_reg ^ s_reg.last_reg) == 8'(1 << FWSR_TOG2_BIT)) begin
          s_next.st = FWSR_IDLE;
          s_next.req = 1'b0;
          s_next.busy = 1'b0;
          s_next.susp = 1'b1;
        end
      end
      FWSR_FINAL: begin
        if (bus.done) begin
          s_next.req = 1'b0;
          s_next.last_reg = bus.rdata;
          s_next.st = FWSR_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end
      end
      FWSR_RESETW: begin
        if (bus.done) begin
          s_next.req = 1'b0;
          s_next.st = FWSR_IDLE;
          s_next.busy = 1'b0;
          s_next.fail = 1'b0;
        end
      end
      default: begin
        s_next.st = FWSR_IDLE;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign bus.req   = s_reg.req;
  assign bus.wr    = s_reg.wr;
  assign bus.addr  = s_reg.baddr;
  assign bus.wdata = s_reg.bwdata;
  assign prdata    = s_reg.prdata;
  assign pready    = s_reg.pready;
  assign pslverr   = s_reg.pslverr;
  a_final_reread: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == FWSR_EVAL && s_next.st == FWSR_FINAL |=> s_reg.req && !s_reg.wr)
    else $error("no reread before done");
  a_fail_after_tout: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_reg.fail) |-> $past(s_reg.tout_seen))
    else $error("fail without timeout recheck");
  a_reset_value: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == FWSR_RESETW && s_reg.req |-> s_reg.wr && s_reg.bwdata == FWSR_CMD_RESET)
    else $error("reset command value wrong");
  a_pready_one: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready longer than one cycle");
  a_done_idle: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_reg.done) |-> s_reg.st == FWSR_IDLE && !s_reg.busy)
    else $error("done while busy");
  c_poll_done: cover property (@(posedge pclk) $rose(s_reg.done) && s_reg.mode == FWSR_MODE_POLL);
  c_tog_done: cover property (@(posedge pclk) $rose(s_reg.done) && s_reg.mode == FWSR_MODE_TOGGLE);
  c_fail: cover property (@(posedge pclk) $rose(s_reg.fail));
  c_susp: cover property (@(posedge pclk) $rose(s_reg.susp));
  c_reset: cover property (@(posedge pclk) s_reg.st == FWSR_RESETW && bus.done);
  // status polling stays on one address and never writes the flash
  a_addr_held: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.busy && $past(s_reg.busy) |-> $stable(s_reg.baddr))
    else $error("poll address moved while busy");
  a_reads_only: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == FWSR_READ || s_reg.st == FWSR_EVAL || s_reg.st == FWSR_FINAL |-> !s_reg.wr)
    else $error("write during status polling");
  a_pair_first: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == FWSR_EVAL && s_next.st == FWSR_FINAL && s_reg.mode != FWSR_MODE_POLL
    |-> s_reg.have_prev)
    else $error("toggle verdict from a single read");
  a_fail_on_read: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_reg.fail) |-> $past(s_reg.st) == FWSR_EVAL)
    else $error("fail raised outside evaluation");
  a_fail_done: assert property (@(posedge pclk) disable iff (!presetn)
    !(s_reg.fail && s_reg.done))
    else $error("fail and done together");
  a_busy_state: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.busy == (s_reg.st != FWSR_IDLE))
    else $error("busy flag out of step with state");
  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("slave error without ready");
  // software may not restart or reset the flash while an operation runs
  a_ctrl_locked: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && pready && paddr == FWSR_OFF_CTRL && s_reg.st != FWSR_IDLE
    |=> $stable(s_reg.mode))
    else $error("control write taken while busy");
  a_susp_erase: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_reg.susp) |-> s_reg.mode == FWSR_MODE_ERASE)
    else $error("suspend outside erase mode");
  a_reset_single: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == FWSR_RESETW && bus.done |=> !s_reg.req && s_reg.st == FWSR_IDLE)
    else $error("reset command repeated");
  a_go_clears: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_reg.busy) && !s_reg.wr |-> !s_reg.done && !s_reg.fail && !s_reg.susp)
    else $error("start kept stale status");
endmodule

// [verilog/fwsr_pkg.sv]
// package for the flash write status polling controller
// assumes a byte-wide parallel flash bus driven by the controller
package fwsr_pkg;
  localparam logic [7:0] FWSR_OFF_CTRL   = 8'h00;
  localparam logic [7:0] FWSR_OFF_ADDR   = 8'h04;
  localparam logic [7:0] FWSR_OFF_DATA   = 8'h08;
  localparam logic [7:0] FWSR_OFF_STATUS = 8'h0c;
  localparam logic [7:0] FWSR_OFF_LAST   = 8'h10;
  localparam int FWSR_CTRL_GO_BIT     = 0;
  localparam int FWSR_CTRL_MODE_LSB   = 1;
  localparam int FWSR_CTRL_RESET_BIT  = 3;
  localparam int FWSR_ST_BUSY_BIT     = 0;
  localparam int FWSR_ST_DONE_BIT     = 1;
  localparam int FWSR_ST_FAIL_BIT     = 2;
  localparam int FWSR_ST_SUSP_BIT     = 3;
  localparam int FWSR_POLL_BIT        = 7;
  localparam int FWSR_TOG1_BIT        = 6;
  localparam int FWSR_TOUT_BIT        = 5;
  localparam int FWSR_TOG2_BIT        = 2;
  localparam logic [7:0] FWSR_CMD_RESET = 8'hf0;
  localparam int FWSR_CLK_MHZ      = 125;
  localparam int FWSR_T_STROBE_NS  = 80;
  localparam int FWSR_STROBE_CYC   = (FWSR_T_STROBE_NS * FWSR_CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    FWSR_MODE_POLL   = 2'b00,
    FWSR_MODE_TOGGLE = 2'b01,
    FWSR_MODE_ERASE  = 2'b10
  } fwsr_mode_t;
  typedef enum logic [3:0] {
    FWSR_IDLE   = 4'b0000,
    FWSR_READ   = 4'b0001,
    FWSR_EVAL   = 4'b0010,
    FWSR_RESETW = 4'b0011,
    FWSR_FINAL  = 4'b0100
  } fwsr_state_t;
endpackage

// [verilog/fwsr_bus_if.sv]
// interface between the sequencer and the flash bus cycle engine
// assumes one clock shared by both ends
interface fwsr_bus_if;
  logic        req;
  logic        wr;
  logic [16:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport master (output req, output wr, output addr, output wdata, input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// [verilog/fwsr_cycle.sv]
// flash bus cycle engine: one read or one write cycle per request
// assumes the flash answers within the fixed strobe width
module fwsr_cycle
  import fwsr_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  fwsr_bus_if.engine  bus,
  input  wire logic [7:0] dq_in,
  output logic [7:0]  dq_out,
  output logic        dq_oe_n,
  output logic [16:0] flash_addr,
  output logic        chip_select_n,
  output logic        output_strobe_n,
  output logic        write_strobe_n
);
  typedef struct packed {
    logic        act;
    logic        wr;
    logic [7:0]  cnt;
    logic        done;
    logic [7:0]  rdata;
    logic [7:0]  dout;
    logic        oe_n;
    logic [16:0] addr;
    logic        cs_n;
    logic        os_n;
    logic        ws_n;
  } fwsr_cyc_t;
  fwsr_cyc_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!s_reg.act) begin
      if (bus.req && !s_reg.done) begin
        s_next.act  = 1'b1;
        s_next.wr   = bus.wr;
        s_next.addr = bus.addr;
        s_next.dout = bus.wdata;
        s_next.cnt  = 8'(FWSR_STROBE_CYC);
        s_next.cs_n = 1'b0;
        s_next.os_n = bus.wr;
        s_next.ws_n = !bus.wr;
        s_next.oe_n = !bus.wr;
      end
    end else if (s_reg.cnt != 8'h00) begin
      s_next.cnt = s_reg.cnt - 8'h01;
    end else begin
      // a rising strobe ends each cycle so toggles advance once per read
      s_next.act   = 1'b0;
      s_next.done  = 1'b1;
      s_next.rdata = dq_in;
      s_next.cs_n  = 1'b1;
      s_next.os_n  = 1'b1;
      s_next.ws_n  = 1'b1;
      s_next.oe_n  = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{act: 1'b0, wr: 1'b0, cnt: 8'h00, done: 1'b0, rdata: 8'h00, dout: 8'h00,
                 oe_n: 1'b1, addr: 17'h0_0000, cs_n: 1'b1, os_n: 1'b1, ws_n: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end
  assign bus.done        = s_reg.done;
  assign bus.rdata       = s_reg.rdata;
  assign dq_out          = s_reg.dout;
  assign dq_oe_n         = s_reg.oe_n;
  assign flash_addr      = s_reg.addr;
  assign chip_select_n   = s_reg.cs_n;
  assign output_strobe_n = s_reg.os_n;
  assign write_strobe_n  = s_reg.ws_n;
  a_strobe_excl: assert property (@(posedge pclk) disable iff (!presetn)
    !(s_reg.os_n == 1'b0 && s_reg.ws_n == 1'b0))
    else $error("both strobes low");
  a_done_ends: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.done |-> s_reg.os_n && s_reg.ws_n && s_reg.cs_n)
    else $error("done while strobe low");
endmodule

// [tb/fwsr_flash_model.sv]
// behavioural byte-wide flash answering status reads during program and erase
// assumes active-low strobes from the controller; no clock, reacts to strobe edges
module fwsr_flash_model
  import fwsr_pkg::*;
(
  input  wire logic        start,
  input  wire logic [1:0]  op,
  input  wire logic [7:0]  pdata,
  input  wire logic [15:0] nreads,
  input  wire logic        tout,
  input  wire logic [16:0] taddr,
  input  wire logic [16:0] flash_addr,
  input  wire logic        chip_select_n,
  input  wire logic        output_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe_n,
  output logic [7:0]       dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // mode: 1 program, 2 erase, 3 erase suspended
  logic [1:0]  mode = 2'd0;
  logic [15:0] left = 16'h0000;
  logic        fail = 1'b0;
  logic        t1   = 1'b0;
  logic        t2   = 1'b0;
  logic        rsel = 1'b0;
  logic        wsel = 1'b0;
  logic [7:0]  arr  = 8'hff;
  logic [7:0]  last = 8'h00;
  logic [7:0]  wd   = 8'h00;
  logic [7:0]  cur;
  logic        busy;
  logic        hit;
  always_comb begin
    // status bits that need the operation's address are wrong elsewhere
    hit = (flash_addr == taddr);
    busy = (mode == 2'd3) || (mode != 2'd0 && (left != 16'h0000 || fail));
    cur = arr;
    if (busy) begin
      cur = 8'h00;
      cur[FWSR_POLL_BIT] = ((mode == 2'd1) ? ~arr[7] : (mode == 2'd3)) ^ !hit;
      cur[FWSR_TOG1_BIT] = t1;
      cur[FWSR_TOUT_BIT] = fail;
      cur[FWSR_TOG2_BIT] = t2;
    end
  end
  // a released bus shows the inverse of the last byte, never a stale copy
  assign dq_in = (!chip_select_n && !output_strobe_n) ? cur : ~last;
  always @(posedge start) begin
    mode = op;
    left = nreads;
    fail = tout;
    arr = (op == 2'd2) ? 8'hff : pdata;
  end
  // select is looked at after the strobe edge, when both pins have settled
  always @(negedge output_strobe_n) #1 rsel = !chip_select_n;
  always @(posedge output_strobe_n) begin
    if (rsel) begin
      last = cur;
      if (busy && mode != 2'd3) t1 = ~t1;
      if (busy && mode[1] && hit) t2 = ~t2;
      if (left != 16'h0000) left = left - 16'h0001;
      if (mode != 2'd3 && left == 16'h0000 && !fail) mode = 2'd0;
    end
  end
  always @(negedge write_strobe_n) #1 wsel = !chip_select_n && !dq_oe_n;
  always @* if (!write_strobe_n) wd = dq_out;
  always @(posedge write_strobe_n) begin
    if (wsel && wd == FWSR_CMD_RESET) begin
      fail = 1'b0;
      mode = 2'd0;
      left = 16'h0000;
    end
  end
endmodule

// [tb/tb.sv]
// self-checking bench for the flash status controller over apb
// assumes the behavioural flash model on the pins and a 125 MHz clock
module tb
  import fwsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} fwsr_exp_t;
  localparam logic [31:0] NONE = 32'h0000_0000;
  localparam logic [31:0] DONE = 32'h0000_0002;
  localparam logic [31:0] FAIL = 32'h0000_0004;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, dq_in, dq_out, m_pd;
  logic [31:0] pwdata, prdata, v;
  logic        dq_oe_n, cs_n, oe_n, we_n, m_go, m_tout;
  logic [16:0] faddr;
  logic [1:0]  m_op;
  logic [15:0] m_nr;
  fwsr_exp_t   q[$];
  fwsr_exp_t   x;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          seed = 16;
  int          cyc = 0;
  fwsr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .flash_addr(faddr), .chip_select_n(cs_n), .output_strobe_n(oe_n),
    .write_strobe_n(we_n));
  fwsr_flash_model flash (.start(m_go), .op(m_op), .pdata(m_pd), .nreads(m_nr),
    .tout(m_tout), .taddr(v[16:0]), .flash_addr(faddr), .chip_select_n(cs_n),
    .output_strobe_n(oe_n), .write_strobe_n(we_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dq_in(dq_in));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      $display("ERROR %0t run did not finish", $time);
      finish_test();
    end
  end
  // result monitor: each completed transfer takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
      x = q.pop_front();
      num_checks++;
      if (pslverr !== x.e) begin
        n_mismatch++;
        $display("ERROR %0t slave error flag wrong at %h", $time, paddr);
      end
      if (!pwrite && x.m != NONE) begin
        num_checks++;
        if ((prdata & x.m) !== x.d) begin
          n_mismatch++;
          $display("ERROR %0t read %h gave %h want %h", $time, paddr, prdata, x.d);
        end
      end
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [31:0] ed, input logic ee,
                      output logic [31:0] r);
    q.push_back('{ed, m, ee});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    logic [31:0] r;
    do xfer(1'b0, FWSR_OFF_STATUS, NONE, NONE, NONE, 1'b0, r);
    while (r[FWSR_ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic run(input logic ld, input logic [1:0] op, input fwsr_mode_t md,
                     input logic to, input logic [15:0] nr, input logic [31:0] st,
                     input string nm);
    logic [31:0] r;
    if (ld) begin
      v = $random(seed);
      xfer(1'b1, FWSR_OFF_ADDR, {15'h0000, v[16:0]}, NONE, NONE, 1'b0, r);
      xfer(1'b1, FWSR_OFF_DATA, {24'h00_0000, v[31:24]}, NONE, NONE, 1'b0, r);
      m_op <= op;
      m_pd <= v[31:24];
      m_nr <= nr;
      m_tout <= to;
      m_go <= 1'b1;
      @(posedge pclk);
      m_go <= 1'b0;
    end
    xfer(1'b1, FWSR_OFF_CTRL, {29'h0000_0000, md, 1'b1}, NONE, NONE, 1'b0, r);
    // a control write while busy must be ignored: mode reads back unchanged
    xfer(1'b1, FWSR_OFF_CTRL, 32'h0000_0008, NONE, NONE, 1'b0, r);
    xfer(1'b0, FWSR_OFF_CTRL, NONE, 32'h0000_0006, {29'h0000_0000, md, 1'b0}, 1'b0, r);
    wait_idle();
    xfer(1'b0, FWSR_OFF_STATUS, NONE, 32'h0000_000f, st, 1'b0, r);
    if (st[FWSR_ST_DONE_BIT])
      xfer(1'b0, FWSR_OFF_LAST, NONE, 32'h0000_00ff,
           (op == 2'd2) ? 32'h0000_00ff : {24'h00_0000, v[31:24]}, 1'b0, r);
    $display("test %s finished", nm);
  endtask
  initial begin
    logic [31:0] r;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = NONE;
    v = NONE;
    m_go = 1'b0;
    m_op = 2'd0;
    m_pd = 8'h00;
    m_nr = 16'h0000;
    m_tout = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, FWSR_OFF_STATUS, NONE, 32'hffff_ffff, NONE, 1'b0, r);
    xfer(1'b0, 8'h14, NONE, NONE, NONE, 1'b1, r);
    $display("test reset values and unmapped address finished");
    run(1'b1, 2'd1, FWSR_MODE_POLL, 1'b0, 16'h0003, DONE, "poll program");
    run(1'b1, 2'd1, FWSR_MODE_TOGGLE, 1'b0, 16'h0005, DONE, "toggle program");
    run(1'b1, 2'd2, FWSR_MODE_ERASE, 1'b0, 16'h0004, DONE, "erase");
    run(1'b1, 2'd3, FWSR_MODE_ERASE, 1'b0, 16'h0000, 32'h0000_0008, "suspend");
    repeat (3) begin
      r = $random(seed);
      run(1'b1, 2'd1, r[0] ? FWSR_MODE_TOGGLE : FWSR_MODE_POLL, 1'b0, {12'h000, r[4:1]},
          DONE, "random program");
    end
    for (int i = 0; i < 2; i++) begin
      run(1'b1, 2'd1, i[0] ? FWSR_MODE_TOGGLE : FWSR_MODE_POLL, 1'b1, 16'h0001, FAIL,
          "timeout");
      xfer(1'b1, FWSR_OFF_CTRL, 32'h0000_0008, NONE, NONE, 1'b0, r);
      wait_idle();
      run(1'b0, 2'd1, FWSR_MODE_POLL, 1'b0, 16'h0000, DONE, "after reset");
    end
    finish_test();
  end
endmodule
